/* isr_pkg.sv */
// Constants shared by the interrupt source router: offsets, codes and reset values.
package isr_pkg;

   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int NUM_SRC  = 30;
   localparam int NUM_INT  = 19;
   localparam int NUM_EXT  = 11;
   localparam int ROUTE_W  = 5;
   localparam int ADDR_W   = 12;
   localparam int DATA_W   = 8;
   localparam int VEC_W    = 25;
   localparam int NMI_BIT  = 24;
   localparam int S1_LSB   = 8;
   localparam int S2_LSB   = 16;

   // ****************************************************************
   // Register offsets and reset value
   // ****************************************************************
   localparam logic [11:0] ECC_ROUTE_OFS = 12'hd18;
   localparam logic [11:0] SRC_OFS [NUM_SRC] = '{
      12'hd1a, 12'hd1b, 12'hd1c, 12'hd20, 12'hd21, 12'hd22,
      12'hd28, 12'hd29, 12'hd30, 12'hd31, 12'hd32, 12'hd33,
      12'hd40, 12'hd41, 12'hd42, 12'hd43, 12'hd44, 12'hd45,
      12'hd46, 12'hd50, 12'hd51, 12'hd52, 12'hd53, 12'hd54,
      12'hd55, 12'hd56, 12'hd57, 12'hd58, 12'hd59, 12'hd5a};
   localparam logic [4:0]  ROUTE_RST     = 5'h00;
   localparam int          ROUTE_LSB     = 0;
   localparam logic [2:0]  RSV_VALUE     = 3'h0;

   // ****************************************************************
   // Routing codes
   // ****************************************************************
   localparam logic [4:0] CODE_OFF     = 5'h00;
   localparam logic [4:0] CODE_M0      = 5'h01;
   localparam logic [4:0] CODE_M1      = 5'h02;
   localparam logic [4:0] CODE_S1_BASE = 5'h03;
   localparam logic [4:0] CODE_S1_LAST = 5'h0a;
   localparam logic [4:0] CODE_M3      = 5'h0b;
   localparam logic [4:0] CODE_M4      = 5'h0c;
   localparam logic [4:0] CODE_S2_BASE = 5'h0d;
   localparam logic [4:0] CODE_S2_LAST = 5'h14;
   localparam logic [4:0] CODE_M6      = 5'h15;
   localparam logic [4:0] CODE_M7      = 5'h16;
   localparam logic [4:0] CODE_NMI     = 5'h1f;

   // Master inputs that take the cascades when a slave is bypassed.
   localparam int M_CASC1 = 2;
   localparam int M_CASC2 = 5;

endpackage

/* isr_router.sv */
// Interrupt source router: routing registers and the decode onto controller inputs and NMI.
//
// Behaviour
// - ECC code zero blocks the ECC interrupt.
// - Six codes drive master inputs 0,1,3,4,6,7.
// - Codes 03-0a drive first slave inputs 0-7.
// - Codes 0d-14 drive second slave inputs 0-7.
// - ECC codes 17 to 1f are blocked.
// - ECC interrupt never produces an NMI.
// - First slave absent: code 03 feeds master 2.
// - Second slave absent: code 0d feeds master 5.
// - Sources sharing an input are ORed together.
// - All NMI-routed sources share the NMI line.
// - Routing register: code bits 4-0, reserved zero.
// - General codes 00 and 17-1e block source.
// - General code 1f routes source to NMI.
// - Thirty sources each have their own register.
`timescale 1ns/100ps

module isr_router (
   // Clock and reset
   input  wire logic                REF_CLK,
   input  wire logic                RST_N,
   // Register access
   input  wire logic [11:0]         MMCR_ADDR,
   input  wire logic                MMCR_WR,
   input  wire logic [7:0]          MMCR_WDATA,
   input  wire logic                MMCR_RD,
   output logic      [7:0]          MMCR_RDATA,
   // Cascade configuration from the master controller
   input  wire logic                SLAVE_ONE_PRESENT,
   input  wire logic                SLAVE_TWO_PRESENT,
   // Interrupt sources
   input  wire logic                ECC_IRQ,
   input  wire logic [18:0]         INT_SRC,
   input  wire logic [10:0]         EXT_IRQ,
   // Controller inputs and NMI
   output logic      [7:0]          MASTER_IRQ,
   output logic      [7:0]          SLAVE1_IRQ,
   output logic      [7:0]          SLAVE2_IRQ,
   output logic                     NMI_REQ
);

   // ****************************************************************
   // Functions
   // ****************************************************************

   // Index of the general routing register at an offset, or -1.
   function automatic int route_index(input logic [11:0] addr);
      int idx;
      idx = -1;
      for (int k = 0; k < isr_pkg::NUM_SRC; k++) begin
         if (addr == isr_pkg::SRC_OFS[k]) begin
            idx = k;
         end
      end
      return idx;
   endfunction

   // Request vector for one source: master 7-0, slave one 15-8, slave two 23-16, NMI 24.
   function automatic logic [24:0] route_decode(input logic [4:0] code,
                                                input logic       allow_nmi,
                                                input logic       s1_on,
                                                input logic       s2_on);
      logic [24:0] v;
      logic [4:0]  ofs;
      v   = '0;
      ofs = 5'h00;
      if (code == isr_pkg::CODE_M0) begin
         v[0] = 1'b1;
      end else if (code == isr_pkg::CODE_M1) begin
         v[1] = 1'b1;
      end else if (code >= isr_pkg::CODE_S1_BASE && code <= isr_pkg::CODE_S1_LAST) begin
         ofs = 5'(code - isr_pkg::CODE_S1_BASE);
         // An absent slave keeps only its base code, moved onto the master input it would cascade into.
         if (s1_on) begin
            v[isr_pkg::S1_LSB + int'(ofs)] = 1'b1;
         end else if (code == isr_pkg::CODE_S1_BASE) begin
            v[isr_pkg::M_CASC1] = 1'b1;
         end
      end else if (code == isr_pkg::CODE_M3) begin
         v[3] = 1'b1;
      end else if (code == isr_pkg::CODE_M4) begin
         v[4] = 1'b1;
      end else if (code >= isr_pkg::CODE_S2_BASE && code <= isr_pkg::CODE_S2_LAST) begin
         ofs = 5'(code - isr_pkg::CODE_S2_BASE);
         if (s2_on) begin
            v[isr_pkg::S2_LSB + int'(ofs)] = 1'b1;
         end else if (code == isr_pkg::CODE_S2_BASE) begin
            v[isr_pkg::M_CASC2] = 1'b1;
         end
      end else if (code == isr_pkg::CODE_M6) begin
         v[6] = 1'b1;
      end else if (code == isr_pkg::CODE_M7) begin
         v[7] = 1'b1;
      end else if (code == isr_pkg::CODE_NMI && allow_nmi) begin
         v[isr_pkg::NMI_BIT] = 1'b1;
      end
      // Codes 00 and 17-1e fall through with nothing set, and 1f too for ECC.
      return v;
   endfunction

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************

   // The general interrupt pins are asynchronous to REF_CLK.
   logic [10:0] ext_meta_q;
   logic [10:0] ext_sync_q;

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         ext_meta_q <= '0;
         ext_sync_q <= '0;
      end else begin
         ext_meta_q <= EXT_IRQ;
         ext_sync_q <= ext_meta_q;
      end
   end

   logic [29:0] src_lvl;
   assign src_lvl = {ext_sync_q, INT_SRC};

   // ****************************************************************
   // Routing registers
   // ****************************************************************
   logic [4:0] route_q [isr_pkg::NUM_SRC];
   logic [4:0] ecc_route_q;
   int         wr_idx;
   int         rd_idx;

   // Reads and writes share one offset table, so every writable register also reads back.
   assign wr_idx = route_index(MMCR_ADDR);
   assign rd_idx = wr_idx;

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         for (int k = 0; k < isr_pkg::NUM_SRC; k++) begin
            route_q[k] <= isr_pkg::ROUTE_RST;
         end
      end else if (MMCR_WR && wr_idx >= 0) begin
         // Reserved bits are dropped so they always read back as zero.
         route_q[wr_idx] <= MMCR_WDATA[4:0];
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         ecc_route_q <= isr_pkg::ROUTE_RST;
      end else if (MMCR_WR && MMCR_ADDR == isr_pkg::ECC_ROUTE_OFS) begin
         ecc_route_q <= MMCR_WDATA[4:0];
      end
   end

   // Read data is registered; unmapped offsets read as zero.
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         MMCR_RDATA <= 8'h00;
      end else if (MMCR_RD) begin
         if (MMCR_ADDR == isr_pkg::ECC_ROUTE_OFS) begin
            MMCR_RDATA <= {isr_pkg::RSV_VALUE, ecc_route_q};
         end else if (rd_idx >= 0) begin
            MMCR_RDATA <= {isr_pkg::RSV_VALUE, route_q[rd_idx]};
         end else begin
            MMCR_RDATA <= 8'h00;
         end
      end
   end

   // ****************************************************************
   // Routing decode
   // ****************************************************************
   logic [24:0] req_d;

   // Each source is decoded in full every cycle; sharing falls out of the OR, so no source hides another.
   always_comb begin
      req_d = route_decode(ecc_route_q, 1'b0, SLAVE_ONE_PRESENT, SLAVE_TWO_PRESENT)
              & {25{ECC_IRQ}};
      for (int k = 0; k < isr_pkg::NUM_SRC; k++) begin
         req_d = req_d | (route_decode(route_q[k], 1'b1, SLAVE_ONE_PRESENT, SLAVE_TWO_PRESENT)
                          & {25{src_lvl[k]}});
      end
   end

   // Outputs are registered so the controllers see glitch-free levels; this costs one cycle.
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         MASTER_IRQ <= 8'h00;
         SLAVE1_IRQ <= 8'h00;
         SLAVE2_IRQ <= 8'h00;
         NMI_REQ    <= 1'b0;
      end else begin
         MASTER_IRQ <= req_d[7:0];
         SLAVE1_IRQ <= req_d[15:8];
         SLAVE2_IRQ <= req_d[23:16];
         NMI_REQ    <= req_d[isr_pkg::NMI_BIT];
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   // Most checks drive one source alone so that the expected output pattern is unambiguous.
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_N);

   sequence s_only_ecc(logic [4:0] code);
      ECC_IRQ && src_lvl == 30'h0 && ecc_route_q == code;
   endsequence

   sequence s_quiet;
      MASTER_IRQ == 8'h00 && SLAVE1_IRQ == 8'h00 && SLAVE2_IRQ == 8'h00 && !NMI_REQ;
   endsequence

   sequence s_only_gen0(logic [4:0] code);
      !ECC_IRQ && src_lvl == 30'h1 && route_q[0] == code;
   endsequence

   // Every stored code is back at its reset value.
   logic codes_clear;

   always_comb begin
      codes_clear = (ecc_route_q == isr_pkg::ROUTE_RST);
      for (int k = 0; k < isr_pkg::NUM_SRC; k++) begin
         codes_clear = codes_clear & (route_q[k] == isr_pkg::ROUTE_RST);
      end
   end

   a_ecc_off_blocks: assert property (s_only_ecc(isr_pkg::CODE_OFF) |=> s_quiet)
      else $error("ECC code zero reached an output");

   a_ecc_master_seven: assert property (s_only_ecc(isr_pkg::CODE_M7) |=> MASTER_IRQ == 8'h80)
      else $error("ECC code 16 did not drive master input 7 alone");

   a_slave_one_route: assert property (s_only_ecc(5'h05) && SLAVE_ONE_PRESENT
                                       |=> SLAVE1_IRQ == 8'h04 && MASTER_IRQ == 8'h00)
      else $error("code 05 did not drive first slave input 2");

   a_slave_two_route: assert property (s_only_ecc(5'h10) && SLAVE_TWO_PRESENT
                                       |=> SLAVE2_IRQ == 8'h08)
      else $error("code 10 did not drive second slave input 3");

   a_ecc_nmi_blocked: assert property (s_only_ecc(isr_pkg::CODE_NMI) |=> s_quiet)
      else $error("ECC code 1f reached an output");

   a_ecc_never_nmi: assert property (src_lvl == 30'h0 |=> !NMI_REQ)
      else $error("NMI raised with only ECC possibly active");

   a_bypass_one: assert property (!SLAVE_ONE_PRESENT |=> SLAVE1_IRQ == 8'h00)
      else $error("first slave driven while absent");

   a_bypass_one_direct: assert property (s_only_ecc(isr_pkg::CODE_S1_BASE) && !SLAVE_ONE_PRESENT
                                         |=> MASTER_IRQ == 8'h04)
      else $error("code 03 did not reach master input 2 with slave absent");

   a_bypass_two_direct: assert property (s_only_ecc(isr_pkg::CODE_S2_BASE) && !SLAVE_TWO_PRESENT
                                         |=> MASTER_IRQ == 8'h20 && SLAVE2_IRQ == 8'h00)
      else $error("code 0d did not reach master input 5 with slave absent");

   a_shared_input: assert property (src_lvl[0] && route_q[0] == isr_pkg::CODE_M0
                                    |=> MASTER_IRQ[0])
      else $error("shared master input 0 not asserted");

   a_shared_nmi: assert property ((src_lvl[1] && route_q[1] == isr_pkg::CODE_NMI) ||
                                  (src_lvl[29] && route_q[29] == isr_pkg::CODE_NMI)
                                  |=> NMI_REQ)
      else $error("NMI-routed source did not raise NMI");

   a_gen_disable: assert property (!ECC_IRQ && src_lvl == 30'h1 && route_q[0] == 5'h17
                                   |=> s_quiet)
      else $error("general code 17 reached an output");

   a_rsv_readzero: assert property (MMCR_RD |=> MMCR_RDATA[7:5] == 3'h0)
      else $error("reserved bits read nonzero");

   a_write_readback: assert property (MMCR_WR && MMCR_ADDR == 12'hd5a ##1 MMCR_RD && MMCR_ADDR == 12'hd5a
                                      |=> MMCR_RDATA[4:0] == $past(MMCR_WDATA[4:0], 2))
      else $error("last routing register did not read back written code");

   a_reset_clear: assert property ($rose(RST_N) |-> codes_clear && MMCR_RDATA == 8'h00
                                   && MASTER_IRQ == 8'h00 && SLAVE1_IRQ == 8'h00
                                   && SLAVE2_IRQ == 8'h00 && !NMI_REQ)
      else $error("state not at reset values after reset");

   a_rdata_holds: assert property (!MMCR_RD |=> $stable(MMCR_RDATA))
      else $error("read data changed without a read");

   a_unmapped_read: assert property (MMCR_RD && rd_idx < 0 && MMCR_ADDR != isr_pkg::ECC_ROUTE_OFS
                                     |=> MMCR_RDATA == 8'h00)
      else $error("unmapped offset read nonzero");

   a_ecc_master_zero: assert property (s_only_ecc(isr_pkg::CODE_M0)
                                       |=> MASTER_IRQ == 8'h01 && SLAVE1_IRQ == 8'h00 && SLAVE2_IRQ == 8'h00)
      else $error("ECC code 01 did not drive master input 0 alone");

   a_gen_master_six: assert property (s_only_gen0(isr_pkg::CODE_M6) |=> MASTER_IRQ == 8'h40 && !NMI_REQ)
      else $error("general code 15 did not drive master input 6");

   a_slave_one_base: assert property (s_only_ecc(isr_pkg::CODE_S1_BASE) && SLAVE_ONE_PRESENT
                                      |=> SLAVE1_IRQ == 8'h01 && MASTER_IRQ == 8'h00)
      else $error("code 03 did not drive first slave input 0 alone");

   a_gen_slave_one: assert property (s_only_gen0(isr_pkg::CODE_S1_LAST) && SLAVE_ONE_PRESENT
                                     |=> SLAVE1_IRQ == 8'h80)
      else $error("general code 0a did not drive first slave input 7");

   a_slave_two_base: assert property (s_only_ecc(isr_pkg::CODE_S2_BASE) && SLAVE_TWO_PRESENT
                                      |=> SLAVE2_IRQ == 8'h01 && MASTER_IRQ == 8'h00)
      else $error("code 0d did not drive second slave input 0 alone");

   a_gen_slave_two: assert property (s_only_gen0(isr_pkg::CODE_S2_LAST) && SLAVE_TWO_PRESENT
                                     |=> SLAVE2_IRQ == 8'h80)
      else $error("general code 14 did not drive second slave input 7");

   a_ecc_high_block: assert property (ECC_IRQ && src_lvl == 30'h0 && ecc_route_q > isr_pkg::CODE_M7
                                      |=> s_quiet)
      else $error("ECC code above 16 reached an output");

   // With a slave absent its upper codes must vanish, not leak onto the master.
   a_bypass_one_range: assert property (ECC_IRQ && src_lvl == 30'h0 && !SLAVE_ONE_PRESENT
                                        && ecc_route_q > isr_pkg::CODE_S1_BASE && ecc_route_q <= isr_pkg::CODE_S1_LAST
                                        |=> s_quiet)
      else $error("first slave code reached an output while slave absent");

   a_bypass_two_range: assert property (ECC_IRQ && src_lvl == 30'h0 && !SLAVE_TWO_PRESENT
                                        && ecc_route_q > isr_pkg::CODE_S2_BASE && ecc_route_q <= isr_pkg::CODE_S2_LAST
                                        |=> s_quiet)
      else $error("second slave code reached an output while slave absent");

   a_bypass_two: assert property (!SLAVE_TWO_PRESENT |=> SLAVE2_IRQ == 8'h00)
      else $error("second slave driven while absent");

   a_gen_zero_block: assert property (s_only_gen0(isr_pkg::CODE_OFF) |=> s_quiet)
      else $error("general code 00 reached an output");

   a_gen_nmi_route: assert property (s_only_gen0(isr_pkg::CODE_NMI)
                                     |=> NMI_REQ && MASTER_IRQ == 8'h00
                                     && SLAVE1_IRQ == 8'h00 && SLAVE2_IRQ == 8'h00)
      else $error("general code 1f did not raise NMI alone");

endmodule

/* isr_pic_model.sv */
// Behavioural model of the cascaded controllers and the CPU NMI input.
`timescale 1ns/100ps

module isr_pic_model (
   // From the router
   input  wire logic [7:0] master_irq,
   input  wire logic [7:0] slave1_irq,
   input  wire logic [7:0] slave2_irq,
   input  wire logic       nmi_req,
   // Controller configuration
   input  wire logic       slave_one_present,
   input  wire logic       slave_two_present,
   input  wire logic [7:0] chan_mask,
   input  wire logic       nmi_global_enable,
   // CPU side
   output logic      [7:0] master_view,
   output logic            cpu_irq,
   output logic            cpu_nmi
);
   // ****************************************************************
   // Cascade and CPU inputs
   // ****************************************************************
   always_comb begin
      master_view    = master_irq;
      master_view[2] = master_irq[2] | (slave_one_present & |slave1_irq);
      master_view[5] = master_irq[5] | (slave_two_present & |slave2_irq);
   end
   // Masks hold back channels only; the NMI path obeys the global enable alone.
   assign cpu_irq = |(master_view & ~chan_mask);
   assign cpu_nmi = nmi_req & nmi_global_enable;
endmodule

/* tb.sv */
// Self-checking testbench for the interrupt source router.
`timescale 1ns/100ps

module tb;
   // ****************************************************************
   // Signals
   // ****************************************************************
   logic        ref_clk = 1'b0;
   logic        rst_n   = 1'b0;
   logic [11:0] addr    = 12'h000;
   logic        wr      = 1'b0;
   logic [7:0]  wdata   = 8'h00;
   logic        rd      = 1'b0;
   logic        p1      = 1'b1;
   logic        p2      = 1'b1;
   logic [30:0] act     = '0;
   logic [7:0]  mask    = 8'hff;
   logic        nmi_en  = 1'b0;
   logic [7:0]  rdata, m_irq, s1_irq, s2_irq, view;
   logic        nmi, cpu_irq, cpu_nmi;
   logic [4:0]  code [31];
   int          err_count = 0;
   int          n_tests   = 0;

   always #20 ref_clk = ~ref_clk;

   isr_router dut (.REF_CLK(ref_clk), .RST_N(rst_n), .MMCR_ADDR(addr), .MMCR_WR(wr), .MMCR_WDATA(wdata),
      .MMCR_RD(rd), .MMCR_RDATA(rdata), .SLAVE_ONE_PRESENT(p1), .SLAVE_TWO_PRESENT(p2), .ECC_IRQ(act[30]),
      .INT_SRC(act[18:0]), .EXT_IRQ(act[29:19]), .MASTER_IRQ(m_irq), .SLAVE1_IRQ(s1_irq),
      .SLAVE2_IRQ(s2_irq), .NMI_REQ(nmi));

   isr_pic_model far (.master_irq(m_irq), .slave1_irq(s1_irq), .slave2_irq(s2_irq), .nmi_req(nmi),
      .slave_one_present(p1), .slave_two_present(p2), .chan_mask(mask), .nmi_global_enable(nmi_en),
      .master_view(view), .cpu_irq(cpu_irq), .cpu_nmi(cpu_nmi));

   // ****************************************************************
   // Expectations and comparisons
   // ****************************************************************
   function automatic logic [24:0] exp_out();
      logic [24:0] v;
      logic [4:0]  c;
      v = '0;
      for (int k = 0; k < 31; k++) begin
         c = code[k];
         if (!act[k]) continue;
         if (c == 5'h1f) v[24] = v[24] | (k != 30);
         else if (c >= 5'h03 && c <= 5'h0a) begin
            if (p1) v[c + 5] = 1'b1;
            else if (c == 5'h03) v[2] = 1'b1;
         end else if (c >= 5'h0d && c <= 5'h14) begin
            if (p2) v[c + 3] = 1'b1;
            else if (c == 5'h0d) v[5] = 1'b1;
         end else begin
            case (c)
               5'h01, 5'h02: v[c - 1] = 1'b1;
               5'h0b, 5'h0c: v[c - 8] = 1'b1;
               5'h15, 5'h16: v[c - 15] = 1'b1;
               default: ;
            endcase
         end
      end
      return v;
   endfunction

   function automatic logic [9:0] exp_far(input logic [24:0] v);
      logic [7:0] m;
      m    = v[7:0];
      m[2] = m[2] | (p1 & |v[15:8]);
      m[5] = m[5] | (p2 & |v[23:16]);
      return {m, |(m & ~mask), v[24] & nmi_en};
   endfunction

   function automatic logic [11:0] ofs(input int k);
      if (k == 30) return isr_pkg::ECC_ROUTE_OFS;
      return isr_pkg::SRC_OFS[k];
   endfunction

   task automatic chk_vec(input logic [24:0] got, input logic [24:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ****************************************************************
   // Bus and sequencing tasks
   // ****************************************************************
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      addr  = a;
      wdata = d;
      wr    = 1'b1;
      @(negedge ref_clk);
      wr = 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
      @(negedge ref_clk);
      addr = a;
      rd   = 1'b1;
      @(negedge ref_clk);
      rd = 1'b0;
      @(negedge ref_clk);
      chk_byte(rdata, e);
   endtask

   // Write then read back in the very next cycle.
   task automatic wr_rd_chk(input int k, input logic [4:0] c);
      @(negedge ref_clk);
      addr  = ofs(k);
      wdata = {3'h0, c};
      wr    = 1'b1;
      @(negedge ref_clk);
      wr = 1'b0;
      rd = 1'b1;
      @(negedge ref_clk);
      rd      = 1'b0;
      code[k] = c;
      chk_byte(rdata, {3'h0, c});
   endtask

   // Masks stay set and the NMI enable clear while routing changes.
   task automatic wr_code(input int k, input logic [4:0] c);
      wr_reg(ofs(k), {3'h0, c});
      code[k] = c;
   endtask

   task automatic settle_chk();
      logic [24:0] e;
      @(negedge ref_clk);
      mask   = 8'h00;
      nmi_en = 1'b1;
      repeat (3) @(negedge ref_clk);
      e = exp_out();
      chk_vec({nmi, s2_irq, s1_irq, m_irq}, e);
      chk_vec({15'h0, view, cpu_irq, cpu_nmi}, {15'h0, exp_far(e)});
      mask   = 8'hff;
      nmi_en = 1'b0;
   endtask

   task automatic do_reset();
      @(negedge ref_clk);
      rst_n = 1'b0;
      repeat (10) @(negedge ref_clk);
      rst_n = 1'b1;
      foreach (code[k]) code[k] = 5'h00;
   endtask

   task automatic chk_regs();
      for (int k = 0; k < 31; k++) rd_chk(ofs(k), {3'h0, code[k]});
   endtask

   task final_report();
      if (err_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      void'($urandom(32'he731f576));
      do_reset();
      chk_regs();
      rd_chk(12'hd1d, 8'h00);
      wr_reg(12'hd1d, 8'h1f);
      wr_reg(ofs(5), 8'hea);
      code[5] = 5'h0a;
      rd_chk(ofs(5), 8'h0a);
      wr_rd_chk(29, 5'($urandom));
      for (int p = 0; p < 2; p++) begin
         p1 = p[0];
         p2 = p[0];
         for (int c = 0; c < 32; c++) begin
            wr_code(0, c[4:0]);
            wr_code(30, c[4:0]);
            act = 31'h0000_0001;
            settle_chk();
            act = 31'h4000_0000;
            settle_chk();
         end
      end
      repeat (60) begin
         repeat (3) wr_code($urandom_range(30), 5'($urandom));
         p1  = 1'($urandom);
         p2  = 1'($urandom);
         act = 31'($urandom);
         settle_chk();
      end
      chk_regs();
      for (int k = 0; k < 31; k++) wr_code(k, 5'h1f);
      repeat (4) begin
         act = 31'($urandom);
         settle_chk();
      end
      do_reset();
      chk_regs();
      final_report();
   end

   initial begin
      repeat (60000) @(posedge ref_clk);
      err_count++;
      final_report();
   end
endmodule
